// [common/csr_pkg.sv]
package csr_pkg;

  // Device register offsets on the link
  localparam logic [7:0]  CLOCK_CONTROL_ZERO_OFF = 8'h29;
  localparam logic [7:0]  CLOCK_CONTROL_ONE_OFF  = 8'h2A;
  localparam logic [7:0]  CLOCK_CONTROL_TWO_OFF  = 8'h2B;
  localparam logic [7:0]  SYSREF_POSITION_OFF    = 8'h2C;
  localparam logic [7:0]  FULL_SCALE_A_OFF       = 8'h30;

  // Reset values
  localparam logic [7:0]  CLOCK_CONTROL_ZERO_RST = 8'h00;
  localparam logic [7:0]  CLOCK_CONTROL_ONE_RST  = 8'h00;
  localparam logic [7:0]  CLOCK_CONTROL_TWO_RST  = 8'h11;
  localparam logic [23:0] SYSREF_POSITION_RST    = 24'h000000;
  localparam logic [15:0] FULL_SCALE_A_RST       = 16'hA000;

  // Field positions
  localparam int SAMPLE_MARKER_BIT  = 3;
  localparam int DEVCLK_PECL_BIT    = 2;
  localparam int SYSREF_PECL_BIT    = 1;
  localparam int SYSREF_INVERT_BIT  = 0;
  localparam int FEEDBACK_GAIN_BIT  = 4;
  localparam int NOISE_SUPPRESS_BIT = 2;
  localparam int DELAY_SEL_MSB      = 3;
  localparam int SAMPLE_DELAY_MSB   = 1;

  // Full-scale limits
  localparam logic [15:0] FULL_SCALE_MIN = 16'h2000;
  localparam logic [15:0] FULL_SCALE_MAX = 16'hFFFF;

  // Host register offsets on the AXI4-Lite bus
  localparam logic [3:0]  HOST_CMD_OFF    = 4'h0;
  localparam logic [3:0]  HOST_WDATA_OFF  = 4'h4;
  localparam logic [3:0]  HOST_RDATA_OFF  = 4'h8;
  localparam logic [3:0]  HOST_STATUS_OFF = 4'hC;
  localparam int          HOST_CMD_WE_BIT = 8;

  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CSR_IDLE  = 2'b00,
    CSR_ISSUE = 2'b01,
    CSR_WAIT  = 2'b10
  } csr_hstate_t;

endpackage : csr_pkg

// [common/csr_link_if.sv]
`timescale 1ns/1ps
// Register access link between host controller and device bank
interface csr_link_if;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;

  modport dev  (input req, input we, input addr, input wdata, output ack, output rdata);
  modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : csr_link_if

// [design/csr_device.sv]
`timescale 1ns/1ps
module csr_device (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  csr_link_if.dev          link,
  input  wire logic        sysref_pin,
  input  wire logic        timestamp_output_enable,
  input  wire logic        down_converter_bypass,
  input  wire logic [15:0] sample_in,
  input  wire logic        sample_valid_in,
  output logic [15:0]      sample_out,
  output logic             sample_valid_out,
  output logic             sysref_aligned,
  output logic             sysref_as_sample_marker_enable,
  output logic             device_clock_dc_pecl_enable,
  output logic             sysref_dc_pecl_enable,
  output logic             sysref_polarity_invert,
  output logic             clock_feedback_gain_high,
  output logic             analog_supply_noise_suppress,
  output logic [1:0]       sample_clock_delay_select,
  output logic [3:0]       sysref_delay_select,
  output logic [15:0]      channel_a_full_scale_code,
  output logic             sysref_position_captured
);

  // Register storage, reserved bits included so they read back
  logic [7:0]  clock_control_zero_q;
  logic [7:0]  clock_control_one_q;
  logic [7:0]  clock_control_two_q;
  logic [23:0] sysref_edge_position_q;
  logic [15:0] channel_a_full_scale_range_q;
  logic        captured_q;

  // Link answer registers
  logic        ack_q;
  logic [31:0] rdata_q;

  // SYSREF path
  logic        sync1_q;
  logic        sync2_q;
  logic [14:0] delay_line_q;
  logic [15:0] delay_taps;
  logic        sysref_used;
  logic        sysref_prev_q;
  logic [23:0] history_q;
  logic        sysref_aligned_q;
  logic        marker_on;

  // Sample path
  logic [15:0] sample_q;
  logic        sample_valid_q;

  // Matches a link address against one register offset
  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a == off);
  endfunction : hits

  logic wr_en;
  assign wr_en = link.req & link.we;

  // Clock control zero: only the delay selection is used here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_control_zero_q <= csr_pkg::CLOCK_CONTROL_ZERO_RST;
    end else if (wr_en && hits(link.addr, csr_pkg::CLOCK_CONTROL_ZERO_OFF)) begin
      clock_control_zero_q <= link.wdata[7:0];
    end
  end

  // Clock control one, all options off after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_control_one_q <= csr_pkg::CLOCK_CONTROL_ONE_RST;
    end else if (wr_en && hits(link.addr, csr_pkg::CLOCK_CONTROL_ONE_OFF)) begin
      clock_control_one_q <= link.wdata[7:0];
    end
  end

  // Clock control two, gain high and first delay tap after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_control_two_q <= csr_pkg::CLOCK_CONTROL_TWO_RST;
    end else if (wr_en && hits(link.addr, csr_pkg::CLOCK_CONTROL_TWO_OFF)) begin
      clock_control_two_q <= link.wdata[7:0];
    end
  end

  // Full-scale code; the low-range limit is left to the host
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_a_full_scale_range_q <= csr_pkg::FULL_SCALE_A_RST;
    end else if (wr_en && hits(link.addr, csr_pkg::FULL_SCALE_A_OFF)) begin
      channel_a_full_scale_range_q <= link.wdata[15:0];
    end
  end

  // Every request is answered one cycle later, writes included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= link.req;
    end
  end

  // Read mux; unmapped addresses and write answers return zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h00000000;
    end else if (link.req && !link.we) begin
      case (link.addr)
        csr_pkg::CLOCK_CONTROL_ZERO_OFF: rdata_q <= {24'h000000, clock_control_zero_q};
        csr_pkg::CLOCK_CONTROL_ONE_OFF:  rdata_q <= {24'h000000, clock_control_one_q};
        csr_pkg::CLOCK_CONTROL_TWO_OFF:  rdata_q <= {24'h000000, clock_control_two_q};
        csr_pkg::SYSREF_POSITION_OFF:    rdata_q <= {8'h00, sysref_edge_position_q};
        csr_pkg::FULL_SCALE_A_OFF:       rdata_q <= {16'h0000, channel_a_full_scale_range_q};
        default:                         rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;

  // SYSREF pin is asynchronous, so two flops come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= sysref_pin;
      sync2_q <= sync1_q;
    end
  end

  // Polarity is fixed before the delay line so every tap sees it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_line_q <= 15'h0000;
    end else begin
      delay_line_q <= {delay_line_q[13:0],
                       sync2_q ^ clock_control_one_q[csr_pkg::SYSREF_INVERT_BIT]};
    end
  end

  // Tap zero is the undelayed signal
  assign delay_taps  = {delay_line_q,
                        sync2_q ^ clock_control_one_q[csr_pkg::SYSREF_INVERT_BIT]};
  assign sysref_used = delay_taps[clock_control_zero_q[csr_pkg::DELAY_SEL_MSB:0]];

  // Sampling history; a rising edge freezes it as the position status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      history_q     <= 24'h000000;
      sysref_prev_q <= 1'b0;
    end else begin
      history_q     <= {history_q[22:0], sysref_used};
      sysref_prev_q <= sysref_used;
    end
  end

  // Host writes never reach this register; it changes only on an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysref_edge_position_q <= csr_pkg::SYSREF_POSITION_RST;
      captured_q             <= 1'b0;
    end else if (sysref_used && !sysref_prev_q) begin
      sysref_edge_position_q <= history_q;
      captured_q             <= 1'b1;
    end
  end

  // Aligned SYSREF for downstream timing logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysref_aligned_q <= 1'b0;
    end else begin
      sysref_aligned_q <= sysref_used;
    end
  end

  // Marking needs both enables and a bypassed down_converter
  assign marker_on = clock_control_one_q[csr_pkg::SAMPLE_MARKER_BIT]
                     & timestamp_output_enable
                     & down_converter_bypass;

  // One cycle of latency on every sample, marked or not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_q       <= 16'h0000;
      sample_valid_q <= 1'b0;
    end else begin
      sample_valid_q <= sample_valid_in;
      if (sample_valid_in) begin
        sample_q <= marker_on ? {sample_in[15:1], sysref_used} : sample_in;
      end
    end
  end

  // Outputs taken straight from register bits
  assign sample_out                     = sample_q;
  assign sample_valid_out               = sample_valid_q;
  assign sysref_aligned                 = sysref_aligned_q;
  assign sysref_as_sample_marker_enable =
    clock_control_one_q[csr_pkg::SAMPLE_MARKER_BIT];
  assign device_clock_dc_pecl_enable    =
    clock_control_one_q[csr_pkg::DEVCLK_PECL_BIT];
  assign sysref_dc_pecl_enable          =
    clock_control_one_q[csr_pkg::SYSREF_PECL_BIT];
  assign sysref_polarity_invert         =
    clock_control_one_q[csr_pkg::SYSREF_INVERT_BIT];
  assign clock_feedback_gain_high       =
    clock_control_two_q[csr_pkg::FEEDBACK_GAIN_BIT];
  assign analog_supply_noise_suppress   =
    clock_control_two_q[csr_pkg::NOISE_SUPPRESS_BIT];
  // Passed on as written; the host keeps it one-hot
  assign sample_clock_delay_select      =
    clock_control_two_q[csr_pkg::SAMPLE_DELAY_MSB:0];
  assign sysref_delay_select            =
    clock_control_zero_q[csr_pkg::DELAY_SEL_MSB:0];
  assign channel_a_full_scale_code      = channel_a_full_scale_range_q;
  assign sysref_position_captured       = captured_q;

endmodule : csr_device

// [design/csr_host.sv]
`timescale 1ns/1ps
// AXI4-Lite controlled master of the device register link
module csr_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        decimation_is_one,
  csr_link_if.host         link
);

  csr_pkg::csr_hstate_t state_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_bus_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_bus_q;
  logic [1:0]  rresp_q;
  logic [7:0]  cmd_addr_q;
  logic        cmd_we_q;
  logic [31:0] cmd_wdata_q;
  logic [31:0] link_rdata_q;
  logic        done_q;
  logic        refused_q;
  logic        req_q;
  logic        wr_fire;
  logic        cmd_go;
  logic        cmd_bad;
  logic [31:0] status_word;

  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_bus_q <= 32'h00000000;
    end else if (bvalid_q && s_axi_bready) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_got_q  <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr;
      end else if (!aw_got_q) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        w_got_q     <= 1'b1;
        wready_q    <= 1'b0;
        wdata_bus_q <= s_axi_wdata;
      end else if (!w_got_q) begin
        wready_q <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;

  // Writes to the command word are checked before they reach the device
  always_comb begin
    cmd_bad = 1'b0;
    if (wdata_bus_q[csr_pkg::HOST_CMD_WE_BIT]) begin
      case (wdata_bus_q[7:0])
        csr_pkg::CLOCK_CONTROL_ONE_OFF:
          cmd_bad = cmd_wdata_q[csr_pkg::SAMPLE_MARKER_BIT] & ~decimation_is_one;
        csr_pkg::CLOCK_CONTROL_TWO_OFF:
          cmd_bad = ~(cmd_wdata_q[1:0] == 2'h1 || cmd_wdata_q[1:0] == 2'h2);
        csr_pkg::FULL_SCALE_A_OFF:
          cmd_bad = cmd_wdata_q[15:0] < csr_pkg::FULL_SCALE_MIN;
        default:
          cmd_bad = 1'b0;
      endcase
    end
  end

  assign cmd_go = wr_fire && awaddr_q == csr_pkg::HOST_CMD_OFF
                  && state_q == csr_pkg::CSR_IDLE && !cmd_bad;

  // Response and host register updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q    <= 1'b0;
      bresp_q     <= csr_pkg::AXI_OKAY;
      cmd_wdata_q <= 32'h00000000;
      cmd_addr_q  <= 8'h00;
      cmd_we_q    <= 1'b0;
      refused_q   <= 1'b0;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= csr_pkg::AXI_OKAY;
      case (awaddr_q)
        csr_pkg::HOST_WDATA_OFF: cmd_wdata_q <= wdata_bus_q;
        csr_pkg::HOST_CMD_OFF: begin
          refused_q <= ~cmd_go;
          if (cmd_go) begin
            cmd_addr_q <= wdata_bus_q[7:0];
            cmd_we_q   <= wdata_bus_q[csr_pkg::HOST_CMD_WE_BIT];
          end
        end
        csr_pkg::HOST_RDATA_OFF, csr_pkg::HOST_STATUS_OFF: bresp_q <= csr_pkg::AXI_OKAY;
        default: bresp_q <= csr_pkg::AXI_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Link sequencer: one request pulse, then wait for the answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= csr_pkg::CSR_IDLE;
      req_q        <= 1'b0;
      done_q       <= 1'b0;
      link_rdata_q <= 32'h00000000;
    end else begin
      req_q <= 1'b0;
      case (state_q)
        csr_pkg::CSR_IDLE: begin
          if (cmd_go) begin
            done_q  <= 1'b0;
            state_q <= csr_pkg::CSR_ISSUE;
          end
        end
        csr_pkg::CSR_ISSUE: begin
          req_q   <= 1'b1;
          state_q <= csr_pkg::CSR_WAIT;
        end
        csr_pkg::CSR_WAIT: begin
          if (link.ack) begin
            if (!cmd_we_q) begin
              link_rdata_q <= link.rdata;
            end
            done_q  <= 1'b1;
            state_q <= csr_pkg::CSR_IDLE;
          end
        end
        default: state_q <= csr_pkg::CSR_IDLE;
      endcase
    end
  end

  assign status_word = {29'h00000000, refused_q, done_q, state_q != csr_pkg::CSR_IDLE};

  // Read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q   <= 1'b0;
      rvalid_q    <= 1'b0;
      rdata_bus_q <= 32'h00000000;
      rresp_q     <= csr_pkg::AXI_OKAY;
    end else if (rvalid_q) begin
      if (s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= csr_pkg::AXI_OKAY;
      case (s_axi_araddr)
        csr_pkg::HOST_CMD_OFF:    rdata_bus_q <= {23'h000000, cmd_we_q, cmd_addr_q};
        csr_pkg::HOST_WDATA_OFF:  rdata_bus_q <= cmd_wdata_q;
        csr_pkg::HOST_RDATA_OFF:  rdata_bus_q <= link_rdata_q;
        csr_pkg::HOST_STATUS_OFF: rdata_bus_q <= status_word;
        default: begin
          rdata_bus_q <= 32'h00000000;
          rresp_q     <= csr_pkg::AXI_SLVERR;
        end
      endcase
    end else begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_bus_q;
  assign s_axi_rresp   = rresp_q;
  assign link.req      = req_q;
  assign link.we       = cmd_we_q;
  assign link.addr     = cmd_addr_q;
  assign link.wdata    = cmd_wdata_q;

endmodule : csr_host

// [testbench/csr_link_checker.sv]
`timescale 1ns/1ps
// Watches the register link between the host and the device bank
module csr_link_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic [31:0] rdata
);
  logic [2:0] written_q;

  // Remembers which config registers saw a write, so reset values are only checked before it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      written_q <= 3'h0;
    end else if (req && we) begin
      written_q <= written_q | {addr == csr_pkg::FULL_SCALE_A_OFF,
                                addr == csr_pkg::CLOCK_CONTROL_TWO_OFF,
                                addr == csr_pkg::CLOCK_CONTROL_ONE_OFF};
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd(logic [7:0] a);
    req && !we && addr == a;
  endsequence

  property p_ack_follows_req;
    req |=> ack;
  endproperty
  property p_ack_has_cause;
    ack |-> $past(req);
  endproperty
  property p_req_single;
    req |=> !req;
  endproperty
  property p_idle_rdata_zero;
    !ack |-> rdata == 32'h0;
  endproperty
  property p_ctrl1_reset;
    s_rd(csr_pkg::CLOCK_CONTROL_ONE_OFF) and !written_q[0] |=> rdata == 32'h0;
  endproperty
  property p_ctrl2_reset;
    s_rd(csr_pkg::CLOCK_CONTROL_TWO_OFF) and !written_q[1] |=> rdata == 32'h11;
  endproperty
  property p_fs_reset;
    s_rd(csr_pkg::FULL_SCALE_A_OFF) and !written_q[2] |=> rdata == 32'hA000;
  endproperty
  property p_pos_width;
    s_rd(csr_pkg::SYSREF_POSITION_OFF) |=> ack && rdata[31:24] == 8'h0;
  endproperty
  property p_ctrl2_onehot;
    s_rd(csr_pkg::CLOCK_CONTROL_TWO_OFF) |=> $onehot(rdata[1:0]);
  endproperty

  a_ack_follows_req: assert property (p_ack_follows_req)
    else $error("link ack missing one cycle after request");
  a_ack_has_cause: assert property (p_ack_has_cause)
    else $error("link ack without a request");
  a_req_single: assert property (p_req_single)
    else $error("link request longer than one cycle");
  a_idle_rdata_zero: assert property (p_idle_rdata_zero)
    else $error("link read data not zero outside ack");
  a_ctrl1_reset: assert property (p_ctrl1_reset)
    else $error("control one not zero after reset");
  a_ctrl2_reset: assert property (p_ctrl2_reset)
    else $error("control two not 0x11 after reset");
  a_fs_reset: assert property (p_fs_reset)
    else $error("full scale code not 0xA000 after reset");
  a_pos_width: assert property (p_pos_width)
    else $error("position read wider than 24 bits");
  a_ctrl2_onehot: assert property (p_ctrl2_onehot)
    else $error("sample delay field not one-hot");

  c_write: cover property (req && we);
  c_pos_read: cover property (s_rd(csr_pkg::SYSREF_POSITION_OFF));
  c_fs_written: cover property (written_q[2]);
  c_fs_min: cover property (req && we && wdata[15:0] == csr_pkg::FULL_SCALE_MIN);
endmodule : csr_link_checker

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        sysref_pin = 1'b0, ts_en = 1'b0, bypass = 1'b0, dec_one = 1'b1, vin = 1'b1;
  logic [15:0] smp_in = 16'h1234;
  logic [15:0] smp_out, fs_code;
  logic        smp_vout, sref_al, mk_en, dclk_pecl, sref_pecl, sref_inv, gain_hi, noise_sup;
  logic        pos_cap;
  logic [1:0]  smp_dly;
  logic [3:0]  sref_dly;
  int          failures = 0;
  int          total_checks = 0;

  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;

  csr_link_if link_i ();
  csr_host csr_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .decimation_is_one(dec_one), .link(link_i));
  csr_device csr_device_i (.aclk(aclk), .aresetn(aresetn), .link(link_i),
    .sysref_pin(sysref_pin), .timestamp_output_enable(ts_en), .down_converter_bypass(bypass),
    .sample_in(smp_in), .sample_valid_in(vin), .sample_out(smp_out),
    .sample_valid_out(smp_vout), .sysref_aligned(sref_al), .sysref_as_sample_marker_enable(mk_en),
    .device_clock_dc_pecl_enable(dclk_pecl), .sysref_dc_pecl_enable(sref_pecl),
    .sysref_polarity_invert(sref_inv), .clock_feedback_gain_high(gain_hi),
    .analog_supply_noise_suppress(noise_sup), .sample_clock_delay_select(smp_dly),
    .sysref_delay_select(sref_dly), .channel_a_full_scale_code(fs_code),
    .sysref_position_captured(pos_cap));
  csr_link_checker csr_link_checker_i (.aclk(aclk), .aresetn(aresetn), .req(link_i.req),
    .we(link_i.we), .addr(link_i.addr), .wdata(link_i.wdata), .ack(link_i.ack),
    .rdata(link_i.rdata));

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stuck(input string what);
    failures++;
    $display("MISMATCH %s expected answer seen timeout", what);
    tally_and_finish();
  endtask : stuck

  // Address and data offered together, each dropped once taken; bready held until bvalid
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 200) stuck("bvalid");
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 200) stuck("rvalid");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // One device access through the host; polls status until done or refused
  task automatic dev(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic exp_ref, output logic [31:0] rd);
    logic [1:0]  r;
    logic [31:0] st;
    int          n;
    axi_wr(csr_pkg::HOST_WDATA_OFF, d, r);
    axi_wr(csr_pkg::HOST_CMD_OFF, {23'h0, wr, a}, r);
    for (n = 0; n < 50; n++) begin
      axi_rd(csr_pkg::HOST_STATUS_OFF, st, r);
      if (st[2] || (st[1] && !st[0])) break;
    end
    if (n == 50) stuck("status");
    chk("refused", {31'h0, exp_ref}, {31'h0, st[2]});
    axi_rd(csr_pkg::HOST_RDATA_OFF, rd, r);
  endtask : dev

  task automatic t_reset();
    logic [7:0]  adr [5] = '{8'h2A, 8'h2B, 8'h30, 8'h2C, 8'h29};
    logic [31:0] exp [5] = '{32'h0, 32'h11, 32'hA000, 32'h0, 32'h0};
    logic [31:0] rd;
    for (int i = 0; i < 5; i++) begin
      dev(1'b0, adr[i], 32'h0, 1'b0, rd);
      chk("reset value", exp[i], rd);
    end
    chk("gain/delay", 32'h5, {29'h0, gain_hi, smp_dly});
    chk("noise suppress", 32'h0, {31'h0, noise_sup});
    chk("full scale out", 32'hA000, {16'h0, fs_code});
    $display("Test reset values done");
  endtask : t_reset

  task automatic t_ctrl_one();
    logic [31:0] rd;
    dev(1'b1, 8'h2A, 32'hF7, 1'b0, rd);
    chk("ctrl one outputs", 32'h7, {28'h0, mk_en, dclk_pecl, sref_pecl, sref_inv});
    dev(1'b0, 8'h2A, 32'h0, 1'b0, rd);
    chk("ctrl one readback", 32'hF7, rd);
    dev(1'b1, 8'h2A, 32'h08, 1'b0, rd);
    chk("ctrl one outputs", 32'h8, {28'h0, mk_en, dclk_pecl, sref_pecl, sref_inv});
    $display("Test control one done");
  endtask : t_ctrl_one

  // Sample marker needs the enable, the output enable and down-converter bypass
  task automatic t_marker();
    logic [31:0] rd;
    dec_one <= 1'b0;
    dev(1'b1, 8'h2A, 32'h0C, 1'b1, rd);
    dec_one <= 1'b1;
    bypass <= 1'b1;
    ts_en <= 1'b1;
    sysref_pin <= 1'b1;
    repeat (25) @(posedge aclk);
    chk("marked sample", 32'h1235, {16'h0, smp_out});
    ts_en <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("unmarked sample", 32'h1234, {16'h0, smp_out});
    ts_en <= 1'b1;
    bypass <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("no bypass sample", 32'h1234, {16'h0, smp_out});
    vin <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("sample valid", 32'h0, {31'h0, smp_vout});
    vin <= 1'b1;
    bypass <= 1'b1;
    dev(1'b1, 8'h2A, 32'h09, 1'b0, rd);
    repeat (10) @(posedge aclk);
    chk("inverted sysref", 32'h1234, {15'h0, sref_al, smp_out});
    dev(1'b1, 8'h2A, 32'h00, 1'b0, rd);
    $display("Test sample marker done");
  endtask : t_marker

  task automatic t_ctrl_two();
    logic [31:0] rd;
    dev(1'b1, 8'h2B, 32'h16, 1'b0, rd);
    chk("ctrl two outputs", 32'hE, {28'h0, gain_hi, noise_sup, smp_dly});
    dev(1'b1, 8'h2B, 32'hE9, 1'b0, rd);
    chk("ctrl two outputs", 32'h1, {28'h0, gain_hi, noise_sup, smp_dly});
    dev(1'b1, 8'h2B, 32'h13, 1'b1, rd);
    dev(1'b0, 8'h2B, 32'h0, 1'b0, rd);
    chk("ctrl two readback", 32'hE9, rd);
    $display("Test control two done");
  endtask : t_ctrl_two

  task automatic t_full_scale();
    logic [31:0] rd;
    dev(1'b1, 8'h30, 32'h2000, 1'b0, rd);
    chk("full scale min", 32'h2000, {16'h0, fs_code});
    dev(1'b1, 8'h30, 32'hFFFF, 1'b0, rd);
    dev(1'b1, 8'h30, 32'h1FFF, 1'b1, rd);
    dev(1'b0, 8'h30, 32'h0, 1'b0, rd);
    chk("full scale readback", 32'hFFFF, rd);
    dev(1'b0, 8'h40, 32'h0, 1'b0, rd);
    chk("unmapped read", 32'h0, rd);
    $display("Test full scale done");
  endtask : t_full_scale

  // A 4-cycle pulse 10 cycles before the capturing edge must show in the history
  task automatic t_position();
    logic [31:0] rd, pos;
    int          ones;
    sysref_pin <= 1'b0;
    repeat (30) @(posedge aclk);
    sysref_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    sysref_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    sysref_pin <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("captured", 32'h1, {31'h0, pos_cap});
    dev(1'b0, 8'h2C, 32'h0, 1'b0, pos);
    ones = $countones(pos);
    chk("pulse in history", 32'h1, {31'h0, ones == 4 || ones == 5});
    dev(1'b1, 8'h2C, 32'h5A5A5A, 1'b0, rd);
    dev(1'b0, 8'h2C, 32'h0, 1'b0, rd);
    chk("position read only", pos, rd);
    dev(1'b1, 8'h29, 32'h80 | ones, 1'b0, rd);
    chk("delay select", ones, {28'h0, sref_dly});
    dev(1'b0, 8'h29, 32'h0, 1'b0, rd);
    chk("ctrl zero readback", 32'h80 | ones, rd);
    $display("Test sysref position done");
  endtask : t_position

  // Main sequence: 20 cycles of reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_ctrl_one();
    t_marker();
    t_ctrl_two();
    t_full_scale();
    t_position();
    tally_and_finish();
  end
endmodule : testbench
